// ### include/mtio_pkg.sv
`default_nettype none
package mtio_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] MTIO_CTRL_OFS       = 8'h00;
    localparam logic [7:0] MTIO_FLAG_SEL_OFS   = 8'h04;
    localparam logic [7:0] MTIO_PIN_STATE_OFS  = 8'h08;
    localparam logic [7:0] MTIO_LAST_TASK_OFS  = 8'h0c;
    localparam logic [7:0] MTIO_IRQ_STATUS_OFS = 8'h10;
    localparam logic [7:0] MTIO_IRQ_ENABLE_OFS = 8'h14;
    localparam logic [7:0] MTIO_IRQ_CLEAR_OFS  = 8'h18;
    localparam int         MTIO_ADDR_W         = 8;

    // control register fields and reset value
    localparam int          MTIO_CTRL_PIN_EN_BIT = 0;
    localparam logic [31:0] MTIO_CTRL_RESET      = 32'h0000_0001;

    // flag select: one 3-bit source index per configurable output
    localparam int          MTIO_SEL_W         = 3;
    localparam int          MTIO_NUM_CFG_FLAGS = 4;
    localparam logic [11:0] MTIO_FLAG_SEL_RESET = 12'h530;

    // block number coding; zero means no task addressed
    localparam int         MTIO_BLOCK_W  = 8;
    localparam logic [7:0] MTIO_NO_BLOCK = 8'h00;

    // interrupt event bit positions
    localparam int MTIO_EV_LAUNCH  = 0;
    localparam int MTIO_EV_RESUME  = 1;
    localparam int MTIO_EV_HOMING  = 2;
    localparam int MTIO_EV_REACHED = 3;
    localparam int MTIO_EV_FERR    = 4;
    localparam int MTIO_EV_STEP    = 5;
    localparam int MTIO_NUM_EV     = 6;

    // bus responses
    localparam logic [1:0] MTIO_RESP_OKAY   = 2'h0;
    localparam logic [1:0] MTIO_RESP_SLVERR = 2'h2;

    // command toward the motion task engine
    typedef struct packed {
        logic                    launch;
        logic                    resume;
        logic                    homing;
        logic [MTIO_BLOCK_W-1:0] number;
    } mtio_cmd_t;

    // status from the motion task engine
    typedef struct packed {
        logic       in_target;
        logic       seq_task_start;
        logic       seq_first;
        logic       ferr_outside;
        logic       limit1;
        logic       limit2;
        logic [7:0] pos_src;
    } mtio_stat_t;
endpackage : mtio_pkg
`default_nettype wire

// ### hdl/mtio_edge.sv
`timescale 1ns/100ps
`default_nettype none
module mtio_edge #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] prev;

    generate
        if (WIDTH < 1)
        begin : g_bad
            $error("mtio_edge: WIDTH must be at least 1");
        end
    endgenerate

    // prev resets high so a line held high through reset does not fire
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            prev <= '1;
        else
            prev <= level;
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_rise
            assign rise[i] = level[i] & ~prev[i];
        end
    endgenerate
endmodule : mtio_edge
`default_nettype wire

// ### hdl/mtio_axil.sv
`timescale 1ns/100ps
`default_nettype none
module mtio_axil
    import mtio_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic [MTIO_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [MTIO_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic                        wr_en,
    output logic [MTIO_ADDR_W-1:0]      wr_addr,
    output logic [31:0]                 wr_data,
    output logic [3:0]                  wr_strb,
    input  wire logic                   wr_ok,
    output logic [MTIO_ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]            rd_data,
    input  wire logic                   rd_ok
);
    logic aw_held;
    logic w_held;

    // address and data may come in either order; hold each until both
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign wr_en         = aw_held & w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_addr       = s_axi_araddr;

    // write address capture
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            aw_held <= 1'b0;
            wr_addr <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            wr_addr <= {s_axi_awaddr[MTIO_ADDR_W-1:2], 2'b00};
        end
        else if (wr_en)
            aw_held <= 1'b0;
    end

    // write data capture
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            w_held  <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held  <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end
        else if (wr_en)
            w_held <= 1'b0;
    end

    // write response, one cycle after both halves are held
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= MTIO_RESP_OKAY;
        end
        else if (wr_en)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? MTIO_RESP_OKAY : MTIO_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // read answer registered in the cycle after the address is taken
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= MTIO_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_ok ? MTIO_RESP_OKAY : MTIO_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule : mtio_axil
`default_nettype wire

// ### hdl/mtio_port.sv
`timescale 1ns/100ps
`default_nettype none
module mtio_port
    import mtio_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic [MTIO_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [MTIO_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    task_resume_in,
    input  wire logic                    task_launch_in,
    input  wire logic [MTIO_BLOCK_W-1:0] block_number_in,
    output logic                         target_reached_out,
    output logic                         sequence_step_out,
    output logic                         following_ok_out,
    output logic                         position_flag0_out,
    output logic                         position_flag1_out,
    output logic                         position_flag2_out,
    output logic                         position_flag3_out,
    output logic                         position_flag4_out,
    output logic                         position_flag5_out,
    output mtio_cmd_t                    engine_cmd,
    input  wire mtio_stat_t              engine_stat,
    output logic                         irq
);
    logic                                    wr_en;
    logic [MTIO_ADDR_W-1:0]                  wr_addr;
    logic [31:0]                             wr_data;
    logic [3:0]                              wr_strb;
    logic                                    wr_ok;
    logic [MTIO_ADDR_W-1:0]                  rd_addr;
    logic [31:0]                             rd_data;
    logic                                    rd_ok;
    logic [31:0]                             ctrl;
    logic [MTIO_NUM_CFG_FLAGS*MTIO_SEL_W-1:0] flag_sel;
    logic [MTIO_NUM_CFG_FLAGS-1:0]           cfg_flag;
    logic [MTIO_NUM_EV-1:0]                  irq_status;
    logic [MTIO_NUM_EV-1:0]                  irq_enable;
    logic [MTIO_NUM_EV-1:0]                  irq_clear;
    logic [MTIO_NUM_EV-1:0]                  events;
    logic [MTIO_NUM_EV-1:0]                  next_irq_status;
    logic [1:0]                              rise;
    logic                                    launch_edge;
    logic                                    resume_edge;
    logic                                    pins_enabled;
    logic                                    no_block;
    logic                                    prev_in_target;
    logic                                    prev_ferr;
    logic [MTIO_BLOCK_W-1:0]                 last_number;
    logic                                    last_homing;

    mtio_axil u_axil (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_ok         (wr_ok),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    // start and resume act on rising edges only; a held level repeats nothing
    mtio_edge #(
        .WIDTH (2)
    ) u_edge (
        .clk     (clk),
        .sys_rst (sys_rst),
        .level   ({task_launch_in, task_resume_in}),
        .rise    (rise)
    );

    // pin commands are dropped while software has the pins disabled
    assign pins_enabled = ctrl[MTIO_CTRL_PIN_EN_BIT];
    assign launch_edge  = rise[1] & pins_enabled;
    assign resume_edge  = rise[0] & pins_enabled;
    assign no_block     = (block_number_in == MTIO_NO_BLOCK);

    // control register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            ctrl <= MTIO_CTRL_RESET;
        else if (wr_en && wr_addr == MTIO_CTRL_OFS && wr_strb[0])
            ctrl <= {24'h00_0000, wr_data[7:0]};
    end

    // source select for the software-configurable flags
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            flag_sel <= MTIO_FLAG_SEL_RESET;
        else if (wr_en && wr_addr == MTIO_FLAG_SEL_OFS)
        begin
            if (wr_strb[0])
                flag_sel[7:0] <= wr_data[7:0];
            if (wr_strb[1])
                flag_sel[11:8] <= wr_data[11:8];
        end
    end

    // launch wins over resume when both rise in the same cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            engine_cmd <= '0;
        else
        begin
            engine_cmd.launch <= launch_edge & ~no_block;
            engine_cmd.homing <= launch_edge & no_block;
            engine_cmd.resume <= resume_edge & ~launch_edge;
            if (launch_edge)
                engine_cmd.number <= block_number_in;
        end
    end

    // last accepted task, kept for software
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            last_number <= MTIO_NO_BLOCK;
            last_homing <= 1'b0;
        end
        else if (launch_edge)
        begin
            last_number <= block_number_in;
            last_homing <= no_block;
        end
    end

    // direct status outputs, registered for clean pin drive
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            target_reached_out <= 1'b0;
            following_ok_out   <= 1'b1;
            position_flag1_out <= 1'b0;
            position_flag2_out <= 1'b0;
        end
        else
        begin
            target_reached_out <= engine_stat.in_target;
            following_ok_out   <= ~engine_stat.ferr_outside;
            position_flag1_out <= engine_stat.limit1;
            position_flag2_out <= engine_stat.limit2;
        end
    end

    // first task of a sequence forces low so the controller can count toggles
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            sequence_step_out <= 1'b0;
        else if (engine_stat.seq_task_start)
        begin
            if (engine_stat.seq_first)
                sequence_step_out <= 1'b0;
            else
                sequence_step_out <= ~sequence_step_out;
        end
    end

    // configurable flags pick a source only by register, never by pin
    genvar g;
    generate
        for (g = 0; g < MTIO_NUM_CFG_FLAGS; g++)
        begin : g_cfg
            assign cfg_flag[g] = engine_stat.pos_src[flag_sel[g*MTIO_SEL_W +: MTIO_SEL_W]];
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            position_flag0_out <= 1'b0;
            position_flag3_out <= 1'b0;
            position_flag4_out <= 1'b0;
            position_flag5_out <= 1'b0;
        end
        else
        begin
            position_flag0_out <= cfg_flag[0];
            position_flag3_out <= cfg_flag[1];
            position_flag4_out <= cfg_flag[2];
            position_flag5_out <= cfg_flag[3];
        end
    end

    // previous levels for event edges
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            prev_in_target <= 1'b0;
            prev_ferr      <= 1'b0;
        end
        else
        begin
            prev_in_target <= engine_stat.in_target;
            prev_ferr      <= engine_stat.ferr_outside;
        end
    end

    // interrupt sources
    always_comb
    begin
        events                  = '0;
        events[MTIO_EV_LAUNCH]  = launch_edge & ~no_block;
        events[MTIO_EV_RESUME]  = resume_edge & ~launch_edge;
        events[MTIO_EV_HOMING]  = launch_edge & no_block;
        events[MTIO_EV_REACHED] = engine_stat.in_target & ~prev_in_target;
        events[MTIO_EV_FERR]    = engine_stat.ferr_outside & ~prev_ferr;
        events[MTIO_EV_STEP]    = engine_stat.seq_task_start;
    end

    // write-one-to-clear; a new event in the same cycle survives the clear
    assign irq_clear       = (wr_en && wr_addr == MTIO_IRQ_CLEAR_OFS && wr_strb[0])
                             ? wr_data[MTIO_NUM_EV-1:0] : '0;
    assign next_irq_status = (irq_status & ~irq_clear) | events;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq_status <= '0;
        else
            irq_status <= next_irq_status;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq_enable <= '0;
        else if (wr_en && wr_addr == MTIO_IRQ_ENABLE_OFS && wr_strb[0])
            irq_enable <= wr_data[MTIO_NUM_EV-1:0];
    end

    assign irq = |(irq_status & irq_enable);

    // writes to read-only or unmapped words answer with an error
    always_comb
    begin
        unique case (wr_addr)
            MTIO_CTRL_OFS, MTIO_FLAG_SEL_OFS, MTIO_IRQ_ENABLE_OFS,
            MTIO_IRQ_CLEAR_OFS: wr_ok = 1'b1;
            default:            wr_ok = 1'b0;
        endcase
    end

    // read mux; the clear register reads as zero
    always_comb
    begin
        rd_data = '0;
        rd_ok   = 1'b1;
        unique case ({rd_addr[MTIO_ADDR_W-1:2], 2'b00})
            MTIO_CTRL_OFS:       rd_data = ctrl;
            MTIO_FLAG_SEL_OFS:   rd_data = {20'h0_0000, flag_sel};
            MTIO_PIN_STATE_OFS:  rd_data = {12'h000, position_flag5_out, position_flag4_out,
                                            position_flag3_out, position_flag2_out,
                                            position_flag1_out, position_flag0_out,
                                            following_ok_out, sequence_step_out,
                                            target_reached_out, task_launch_in,
                                            task_resume_in, 1'b0, block_number_in};
            MTIO_LAST_TASK_OFS:  rd_data = {23'h00_0000, last_homing, last_number};
            MTIO_IRQ_STATUS_OFS: rd_data = {26'h000_0000, irq_status};
            MTIO_IRQ_ENABLE_OFS: rd_data = {26'h000_0000, irq_enable};
            MTIO_IRQ_CLEAR_OFS:  rd_data = '0;
            default:             rd_ok   = 1'b0;
        endcase
    end
endmodule : mtio_port
`default_nettype wire

// ### bench/mtio_port_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mtio_port_monitor
    import mtio_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       task_resume_in,
    input  wire logic       task_launch_in,
    input  wire logic [7:0] block_number_in,
    input  wire logic       target_reached_out,
    input  wire logic       sequence_step_out,
    input  wire logic       following_ok_out,
    input  wire logic       position_flag1_out,
    input  wire logic       position_flag2_out,
    input  wire mtio_cmd_t  engine_cmd,
    input  wire mtio_stat_t engine_stat
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // start pin rising
    sequence s_launch_rise;
        !task_launch_in ##1 task_launch_in;
    endsequence

    chk_target_follow: assert property (
        !$past(sys_rst) |-> target_reached_out == $past(engine_stat.in_target))
        else $error("target output wrong");
    chk_step_first: assert property (
        engine_stat.seq_task_start && engine_stat.seq_first |=> !sequence_step_out)
        else $error("step not low at first task");
    chk_step_toggle: assert property (
        engine_stat.seq_task_start && !engine_stat.seq_first
        |=> sequence_step_out != $past(sequence_step_out))
        else $error("step did not toggle");
    chk_step_hold: assert property (
        !engine_stat.seq_task_start |=> $stable(sequence_step_out))
        else $error("step moved without task");
    chk_ferr_level: assert property (
        !$past(sys_rst) |-> following_ok_out != $past(engine_stat.ferr_outside))
        else $error("following output wrong");
    chk_flag_one: assert property (
        !$past(sys_rst) |-> position_flag1_out == $past(engine_stat.limit1))
        else $error("flag one wrong");
    chk_flag_two: assert property (
        !$past(sys_rst) |-> position_flag2_out == $past(engine_stat.limit2))
        else $error("flag two wrong");
    chk_launch_edge: assert property (
        engine_cmd.launch |-> $past(task_launch_in) && !$past(task_launch_in, 2)
        && $past(block_number_in) != MTIO_NO_BLOCK)
        else $error("launch without edge");
    chk_homing_zero: assert property (
        engine_cmd.homing |-> $past(block_number_in) == MTIO_NO_BLOCK
        && $past(task_launch_in) && !$past(task_launch_in, 2))
        else $error("homing wrongly issued");
    chk_resume_edge: assert property (
        engine_cmd.resume |-> !engine_cmd.launch && !engine_cmd.homing
        && $past(task_resume_in) && !$past(task_resume_in, 2))
        else $error("resume wrongly issued");
    chk_cmd_number: assert property (
        s_launch_rise ##1 engine_cmd.launch |-> engine_cmd.number == $past(block_number_in))
        else $error("wrong block number");
    chk_pulse_single: assert property (
        s_launch_rise ##1 engine_cmd.launch |=> !engine_cmd.launch)
        else $error("launch pulse too long");
endmodule : mtio_port_monitor

bind mtio_port mtio_port_monitor i_mon (.*);
`default_nettype wire

// ### bench/mtio_plc_model.sv
`timescale 1ns/100ps
`default_nettype none
module mtio_plc_model
    import mtio_pkg::*;
(
    input  wire logic  clk,
    output logic       task_launch_in,
    output logic       task_resume_in,
    output logic [7:0] block_number_in
);
    // idle start pins low, number lines at 5a
    initial
    begin
        {task_launch_in, task_resume_in, block_number_in} = 10'h05a;
    end

    // number first, start pins after the hold
    task press(input logic go, input logic rs, input logic [7:0] v, input int hold);
        @(posedge clk);
        block_number_in <= v;
        repeat (hold) @(posedge clk); // number stable before start
        task_launch_in <= go;
        task_resume_in <= rs;
        repeat (2) @(posedge clk);
        task_launch_in <= 1'b0;
        task_resume_in <= 1'b0;
        @(posedge clk);
        block_number_in <= ~v; // released lines carry the inverted number
    endtask : press
endmodule : mtio_plc_model
`default_nettype wire

// ### bench/tb_mtio_port.sv
`timescale 1ns/100ps
`default_nettype none
module tb_mtio_port
    import mtio_pkg::*;
;
    logic        clk, sys_rst, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, n;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, exp_step;
    logic        target_reached_out, sequence_step_out, following_ok_out;
    logic [5:0]  flag;
    logic [11:0] fs;
    wire logic   task_resume_in, task_launch_in;
    wire [7:0]   block_number_in;
    mtio_cmd_t   engine_cmd, last;
    mtio_stat_t  engine_stat, st;
    int          err_total, compares, cyc, n_go, n_res;

    mtio_port i_dut (
        .*,
        .position_flag0_out(flag[0]), .position_flag1_out(flag[1]),
        .position_flag2_out(flag[2]), .position_flag3_out(flag[3]),
        .position_flag4_out(flag[4]), .position_flag5_out(flag[5])
    );
    mtio_plc_model i_plc (.*);

    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task finish_test;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    // one write; each half released once taken
    task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er);
    endtask : axw

    task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, d);
        check(s_axi_rresp, er);
    endtask : axr

    function automatic logic [8:0] exp_task(input logic [7:0] v);
        return {v == MTIO_NO_BLOCK, v};
    endfunction : exp_task

    function automatic logic exp_seq(input mtio_stat_t s, input logic q);
        return s.seq_task_start ? ~q & ~s.seq_first : q;
    endfunction : exp_seq

    // command tally, then watchdog last
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (engine_cmd.launch | engine_cmd.homing) n_go <= n_go + 1;
        if (engine_cmd.launch | engine_cmd.homing) last <= engine_cmd;
        if (engine_cmd.resume) n_res <= n_res + 1;
        if (cyc == 30000)
        begin
            err_total++;
            finish_test();
        end
    end

    initial
    begin
        {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hf;
        engine_stat = '0;
        {err_total, compares, cyc, n_go, n_res} = '0;
        void'($urandom(32'hea156435));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        axr(MTIO_CTRL_OFS, 32'h1, MTIO_RESP_OKAY);
        axr(MTIO_FLAG_SEL_OFS, 32'h530, MTIO_RESP_OKAY);
        axr(MTIO_IRQ_ENABLE_OFS, 32'h0, MTIO_RESP_OKAY);
        axr(8'h1c, 32'h0, MTIO_RESP_SLVERR);
        axw(MTIO_PIN_STATE_OFS, 32'hffff, MTIO_RESP_SLVERR);
        // corner numbers first, resume raised with every odd launch
        for (int i = 0; i < 12; i++)
        begin
            n = (i == 0) ? 8'h00 : (i == 1) ? 8'hae : (i == 2) ? 8'hff : 8'($urandom);
            i_plc.press(1'b1, i[0], n, 1 + i % 3);
            repeat (2) @(posedge clk);
            check(n_go, i + 1);
            check(n_res, 0);
            check({last.homing, last.number}, exp_task(n));
        end
        axr(MTIO_LAST_TASK_OFS, 32'(exp_task(n)), MTIO_RESP_OKAY);
        i_plc.press(1'b0, 1'b1, 8'h11, 1);
        repeat (2) @(posedge clk);
        check(n_res, 1);
        // pins disabled: no command may issue
        axw(MTIO_CTRL_OFS, 32'h0, MTIO_RESP_OKAY);
        i_plc.press(1'b1, 1'b1, 8'h22, 1);
        repeat (2) @(posedge clk);
        check(n_go + n_res, 13);
        axw(MTIO_CTRL_OFS, 32'h1, MTIO_RESP_OKAY);
        // interrupt raised, then masked while status sticks
        axw(MTIO_IRQ_CLEAR_OFS, 32'h3f, MTIO_RESP_OKAY);
        axw(MTIO_IRQ_ENABLE_OFS, 32'h1, MTIO_RESP_OKAY);
        check(irq, 1'b0);
        for (int k = 0; k < 2; k++)
        begin
            i_plc.press(1'b1, 1'b0, 8'h33, 2);
            repeat (2) @(posedge clk);
            check(irq, 1'(k == 0));
            axr(MTIO_IRQ_STATUS_OFS, 32'h1, MTIO_RESP_OKAY);
            axw(MTIO_IRQ_CLEAR_OFS, 32'h1, MTIO_RESP_OKAY);
            axw(MTIO_IRQ_ENABLE_OFS, 32'h0, MTIO_RESP_OKAY);
            check(irq, 1'b0);
        end
        // random status with random flag routing
        fs = 12'($urandom);
        axw(MTIO_FLAG_SEL_OFS, 32'(fs), MTIO_RESP_OKAY);
        exp_step = 1'b0;
        for (int i = 0; i < 60; i++)
        begin
            st = 14'($urandom);
            @(posedge clk);
            engine_stat <= st;
            @(posedge clk);
            engine_stat.seq_task_start <= 1'b0;
            exp_step = exp_seq(st, exp_step);
            #1;
            check(target_reached_out, st.in_target);
            check(sequence_step_out, exp_step);
            check(following_ok_out, !st.ferr_outside);
            check(flag[1], st.limit1);
            check(flag[2], st.limit2);
            check({flag[5], flag[4], flag[3], flag[0]}, {st.pos_src[fs[11:9]],
                st.pos_src[fs[8:6]], st.pos_src[fs[5:3]], st.pos_src[fs[2:0]]});
        end
        finish_test();
    end
endmodule : tb_mtio_port
`default_nettype wire
